// ===== hw/rcd_pkg.sv
// constants, command codes and state records of the rheostat command decoder
// assumes a 10 MHz system clock and a word-level link on a clock of its own
package rcd_pkg;
   localparam int MCLK_HZ = 10_000_000;
   localparam int STORE_MS = 350;
   localparam int STORE_CYC = STORE_MS * (MCLK_HZ / 1000);
   localparam int CNT_W = 22;
   localparam int SLOTS = 50;

   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER = 4'h1;
   localparam logic [3:0] CMD_RD_WIPER = 4'h2;
   localparam logic [3:0] CMD_STORE = 4'h3;
   localparam logic [3:0] CMD_REFRESH = 4'h4;
   localparam logic [3:0] CMD_RD_STORE = 4'h5;
   localparam logic [3:0] CMD_RD_LAST = 4'h6;
   localparam logic [3:0] CMD_WR_CTRL = 4'h7;
   localparam logic [3:0] CMD_RD_CTRL = 4'h8;
   localparam logic [3:0] CMD_SHUTDOWN = 4'h9;

   // command word fields
   localparam int CODE_HI = 13;
   localparam int CODE_LO = 10;
   localparam int DATA_HI = 9;
   localparam int ADDR_HI = 5;

   // control readback bit positions
   localparam int CTL_SUCCESS_BIT = 3;
   localparam int CTL_UNLOCK_BIT = 1;
   localparam int CTL_ENABLE_BIT = 0;

   // store map locations
   localparam logic [5:0] LOC_FIRST_SLOT = 6'h01;
   localparam logic [5:0] LOC_LAST_SLOT = 6'h32;
   localparam logic [5:0] LOC_TOL_UPPER = 6'h39;
   localparam logic [5:0] LOC_TOL_LOWER = 6'h3a;
   localparam logic [5:0] PTR_FULL = 6'h32;

   localparam logic [9:0] WIPER_MID = 10'h200;
   localparam logic [15:0] WORD_RST = 16'h0000;

   typedef enum logic {ST_IDLE = 1'b0, ST_STORE = 1'b1} rcd_st_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic hw_s1;
      logic hw_s2;
      rcd_st_t st;
      logic [CNT_W-1:0] cnt;
      logic [9:0] wiper;
      logic unlock;
      logic store_en;
      logic success;
      logic shutdown;
      logic [5:0] ptr;
      logic [SLOTS-1:0][9:0] mem;
      logic [15:0] rb;
      logic ack_tgl;
   } rcd_core_t;

   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic ack_s1;
      logic ack_s2;
      logic ack_seen;
      logic req_tgl;
      logic pend;
      logic ready;
      logic [15:0] word;
      logic [15:0] rdata;
   } rcd_link_t;
endpackage

// ===== hw/rcd_core.sv
// command decoder, wiper register, one-time store and protection of a rheostat
// assumes a link engine on i_lclk that hands over whole 16-bit command words
// and collects the readback word; the hardware reset pin is asynchronous
`timescale 1ns/1ps

module rcd_core #(
   parameter int STORE_CYCLES = rcd_pkg::STORE_CYC,
   parameter logic [9:0] TOL_UPPER = 10'h000, // arbitrary neutral value
   parameter logic [9:0] TOL_LOWER = 10'h000 // arbitrary neutral value
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_hw_reset_n,
   input wire logic i_lclk,
   input wire logic i_lnk_valid,
   input wire logic [15:0] i_lnk_word,
   output logic o_lnk_ready,
   output logic [15:0] o_lnk_rdata,
   output logic [9:0] o_wiper,
   output logic o_shutdown,
   output logic o_store_busy
);
   rcd_pkg::rcd_core_t cq;
   rcd_pkg::rcd_core_t cd;
   rcd_pkg::rcd_link_t lq;
   rcd_pkg::rcd_link_t ld;

   logic go;
   logic hw_low;
   logic [3:0] code;
   logic [9:0] data;
   logic [5:0] addr;
   logic [9:0] last_val;
   logic [9:0] loc_val;

   localparam logic [rcd_pkg::CNT_W-1:0] STORE_LAST =
      rcd_pkg::CNT_W'(STORE_CYCLES - 1);

   // ---------------- link domain ----------------
   always_comb
   begin
      ld = lq;
      ld.rst_s1 = i_rst_n;
      ld.rst_s2 = lq.rst_s1;
      ld.ack_s1 = cq.ack_tgl;
      ld.ack_s2 = lq.ack_s1;
      if (!lq.rst_s2)
      begin
         ld.ack_seen = 1'b0;
         ld.req_tgl = 1'b0;
         ld.pend = 1'b0;
         ld.word = rcd_pkg::WORD_RST;
         ld.rdata = rcd_pkg::WORD_RST;
      end
      else
      begin
         // word stays frozen while the core owns it
         if (i_lnk_valid && lq.ready)
         begin
            ld.word = i_lnk_word;
            ld.req_tgl = ~lq.req_tgl;
            ld.pend = 1'b1;
         end
         // answer toggles only after a store has finished, so a store
         // keeps the link unacknowledged for its whole length
         if (lq.ack_s2 != lq.ack_seen)
         begin
            ld.ack_seen = lq.ack_s2;
            ld.rdata = cq.rb;
            ld.pend = 1'b0;
         end
      end
      ld.ready = lq.rst_s2 && !ld.pend;
   end

   always_ff @(posedge i_lclk)
   begin
      lq <= ld;
   end

   // ---------------- core domain ----------------
   always_comb
   begin
      go = (cq.req_s2 != cq.req_seen) && (cq.st == rcd_pkg::ST_IDLE);
      hw_low = !cq.hw_s2;
      code = lq.word[rcd_pkg::CODE_HI:rcd_pkg::CODE_LO];
      data = lq.word[rcd_pkg::DATA_HI:0];
      addr = data[rcd_pkg::ADDR_HI:0];
      if (cq.ptr == 6'h00)
         last_val = rcd_pkg::WIPER_MID;
      else
         last_val = cq.mem[cq.ptr - 6'h01];
      if (addr >= rcd_pkg::LOC_FIRST_SLOT && addr <= rcd_pkg::LOC_LAST_SLOT)
         loc_val = cq.mem[addr - 6'h01];
      else if (addr == rcd_pkg::LOC_TOL_UPPER)
         loc_val = TOL_UPPER;
      else if (addr == rcd_pkg::LOC_TOL_LOWER)
         loc_val = TOL_LOWER;
      else
         loc_val = 10'h000;
   end

   always_comb
   begin
      cd = cq;
      cd.req_s1 = lq.req_tgl;
      cd.req_s2 = cq.req_s1;
      cd.hw_s1 = i_hw_reset_n;
      cd.hw_s2 = cq.hw_s1;
      if (!i_rst_n)
      begin
         cd.req_seen = 1'b0;
         cd.st = rcd_pkg::ST_IDLE;
         cd.cnt = '0;
         cd.wiper = rcd_pkg::WIPER_MID;
         cd.unlock = 1'b0;
         cd.store_en = 1'b0;
         cd.success = 1'b0;
         cd.shutdown = 1'b0;
         cd.ptr = 6'h00;
         cd.mem = '0;
         cd.rb = rcd_pkg::WORD_RST;
         cd.ack_tgl = 1'b0;
      end
      else
      begin
         case (cq.st)
            rcd_pkg::ST_IDLE:
            begin
               if (go)
               begin
                  cd.req_seen = cq.req_s2;
                  cd.ack_tgl = ~cq.ack_tgl;
                  // commands other than the four reads echo the word back as the answer of the same frame
                  cd.rb = lq.word;
                  case (code)
                     rcd_pkg::CMD_WR_WIPER:
                        if (cq.unlock)
                           cd.wiper = data;
                     rcd_pkg::CMD_RD_WIPER:
                        cd.rb = {6'h00, cq.wiper};
                     rcd_pkg::CMD_STORE:
                        if (cq.store_en && cq.ptr < rcd_pkg::PTR_FULL)
                        begin
                           cd.mem[cq.ptr] = cq.wiper;
                           cd.st = rcd_pkg::ST_STORE;
                           cd.cnt = STORE_LAST;
                           cd.ack_tgl = cq.ack_tgl;
                        end
                     rcd_pkg::CMD_REFRESH:
                     begin
                        cd.wiper = last_val;
                        cd.shutdown = 1'b0;
                     end
                     rcd_pkg::CMD_RD_STORE:
                        cd.rb = {6'h00, loc_val};
                     rcd_pkg::CMD_RD_LAST:
                        cd.rb = {10'h000, cq.ptr};
                     rcd_pkg::CMD_WR_CTRL:
                     begin
                        cd.unlock = data[1];
                        cd.store_en = data[0];
                     end
                     rcd_pkg::CMD_RD_CTRL:
                     begin
                        cd.rb = 16'h0000;
                        cd.rb[rcd_pkg::CTL_SUCCESS_BIT] = cq.success;
                        cd.rb[rcd_pkg::CTL_UNLOCK_BIT] = cq.unlock;
                        cd.rb[rcd_pkg::CTL_ENABLE_BIT] = cq.store_en;
                     end
                     rcd_pkg::CMD_SHUTDOWN:
                        cd.shutdown = data[0];
                     default:
                        cd.rb = lq.word;
                  endcase
               end
            end
            rcd_pkg::ST_STORE:
            begin
               // fuse programming is not aborted once begun
               if (cq.cnt == '0)
               begin
                  cd.st = rcd_pkg::ST_IDLE;
                  cd.ptr = cq.ptr + 6'h01;
                  cd.success = 1'b1;
                  cd.ack_tgl = ~cq.ack_tgl;
               end
               else
                  cd.cnt = cq.cnt - rcd_pkg::CNT_W'(1);
            end
            default:
               cd.st = rcd_pkg::ST_IDLE;
         endcase
         // pin reset wins over a command in the same cycle
         if (hw_low)
         begin
            cd.unlock = 1'b0;
            cd.store_en = 1'b0;
            cd.shutdown = 1'b0;
            cd.wiper = last_val;
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      cq <= cd;
   end

   assign o_lnk_ready = lq.ready;
   assign o_lnk_rdata = lq.rdata;
   assign o_wiper = cq.wiper;
   assign o_shutdown = cq.shutdown;
   assign o_store_busy = cq.st;

   // ---------------- checks ----------------
   a_wiper_write_ok: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_WR_WIPER && cq.unlock && cq.hw_s2
      |=> o_wiper == $past(data))
      else $error("unlocked wiper write not applied");

   a_wiper_locked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_WR_WIPER && !cq.unlock && cq.hw_s2
      |=> $stable(o_wiper))
      else $error("locked wiper changed");

   a_store_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_STORE && (!cq.store_en || cq.ptr == rcd_pkg::PTR_FULL)
      |=> cq.st == rcd_pkg::ST_IDLE && $stable(cq.ptr) && $stable(cq.success))
      else $error("refused store changed state");

   a_store_commit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $fell(o_store_busy) |-> cq.success && cq.ptr == $past(cq.ptr) + 6'h01)
      else $error("store end without success or advance");

   a_store_silent: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cq.st == rcd_pkg::ST_STORE && cq.cnt != '0 |=> $stable(cq.ack_tgl) && $stable(cq.rb))
      else $error("answer given during store");

   a_ctrl_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_WR_CTRL && cq.hw_s2
      |=> cq.unlock == $past(data[1]) && cq.store_en == $past(data[0]))
      else $error("control write mismatch");

   a_shutdown_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_SHUTDOWN && cq.hw_s2 |=> o_shutdown == $past(data[0]))
      else $error("shutdown not per data bit 0");

   a_hw_reset_clr: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      hw_low |=> !cq.unlock && !cq.store_en && !o_shutdown && o_wiper == $past(last_val))
      else $error("pin reset did not clear control");

   a_ctrl_layout: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_CTRL
      |=> cq.rb[15:4] == 12'h000 && cq.rb[2] == 1'b0 && cq.rb[3] == $past(cq.success))
      else $error("control readback layout wrong");

   a_refresh_last: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_REFRESH && cq.hw_s2 |=> o_wiper == $past(last_val))
      else $error("refresh did not load last stored value");

   a_link_hold: assert property (@(posedge i_lclk) disable iff (!lq.rst_s2)
      lq.pend && !(lq.ack_s2 != lq.ack_seen) |=> $stable(lq.word) && !o_lnk_ready)
      else $error("link word changed while owned by core");

   // store start and slot contents
   a_store_enter: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_STORE && cq.store_en && cq.ptr < rcd_pkg::PTR_FULL
      |=> cq.st == rcd_pkg::ST_STORE && cq.cnt == STORE_LAST)
      else $error("enabled store did not start");

   a_store_slot: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_STORE && cq.store_en && cq.ptr < rcd_pkg::PTR_FULL
      |=> cq.mem[$past(cq.ptr)] == $past(cq.wiper))
      else $error("stored slot does not hold the wiper");

   a_busy_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      $rose(o_store_busy) |-> cq.cnt == STORE_LAST)
      else $error("store began with a wrong length");

   a_ptr_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      !$fell(o_store_busy) |-> $stable(cq.ptr))
      else $error("pointer moved outside a finished store");

   a_success_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      cq.success |=> cq.success)
      else $error("success flag lost");

   // readback words returned as the answer of the same frame
   a_rd_wiper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_WIPER
      |=> cq.rb == {6'h00, $past(cq.wiper)})
      else $error("wiper readback wrong");

   a_rd_last: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_LAST
      |=> cq.rb == {10'h000, $past(cq.ptr)})
      else $error("last slot readback wrong");

   a_ctrl_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_CTRL
      |=> cq.rb[1] == $past(cq.unlock) && cq.rb[0] == $past(cq.store_en))
      else $error("control readback bits wrong");

   a_tol_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_STORE && addr == rcd_pkg::LOC_TOL_UPPER
      |=> cq.rb == {6'h00, TOL_UPPER})
      else $error("upper tolerance word wrong");

   a_tol_lower: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_STORE && addr == rcd_pkg::LOC_TOL_LOWER
      |=> cq.rb == {6'h00, TOL_LOWER})
      else $error("lower tolerance word wrong");

   a_loc_reserved: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_RD_STORE && addr == 6'h00
      |=> cq.rb == 16'h0000)
      else $error("reserved location not zero");

   // no-operation and refresh commands and the answer path
   a_nop_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_NOP && cq.hw_s2
      |=> $stable(o_wiper) && $stable(o_shutdown) && $stable(cq.unlock)
      && $stable(cq.store_en) && $stable(cq.ptr))
      else $error("no-operation word changed state");

   a_refresh_wake: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code == rcd_pkg::CMD_REFRESH |=> !o_shutdown)
      else $error("refresh left shutdown on");

   a_answer_given: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      go && code != rcd_pkg::CMD_STORE |=> cq.ack_tgl != $past(cq.ack_tgl))
      else $error("plain command not answered");

   // a taken word must drop ready at once, or a second word could slip in
   a_link_take: assert property (@(posedge i_lclk) disable iff (!lq.rst_s2)
      i_lnk_valid && o_lnk_ready |=> !o_lnk_ready && lq.word == $past(i_lnk_word))
      else $error("offered word not taken");
endmodule

// ===== tb/rcd_host.sv
// host model at the link side: offers one command word at a time and collects the answer
// assumes the core takes a word on an edge where ready is high and answers by raising ready
`timescale 1ns/1ps
module rcd_host (
   output logic o_lclk,
   output logic o_valid,
   output logic [15:0] o_word,
   input wire logic i_ready,
   input wire logic [15:0] i_rdata
);
   logic run = 1'b1;

   initial
   begin
      o_lclk = 1'b0;
      o_valid = 1'b0;
      o_word = 16'h0000;
   end

   // link clock runs from start-up until the first frame ends, then only while a frame is open, and parks low
   always
   begin
      #62.5;
      if (run || o_lclk)
         o_lclk = ~o_lclk;
   end

   task automatic send(input logic [15:0] w, output logic [15:0] r, output bit ok);
      int n;
      run = 1'b1;
      ok = 1'b0;
      r = 16'h0000;
      @(posedge o_lclk);
      o_valid <= 1'b1;
      o_word <= w;
      for (n = 0; n < 50 && !ok; n++)
      begin
         @(posedge o_lclk);
         ok = (i_ready === 1'b1);
      end
      o_valid <= 1'b0;
      // a released word does not keep showing the last value
      o_word <= ~w;
      if (ok)
      begin
         ok = 1'b0;
         for (n = 0; n < 400 && !ok; n++)
         begin
            @(posedge o_lclk);
            ok = (i_ready === 1'b1);
         end
         r = i_rdata;
      end
      run = 1'b0;
   endtask
endmodule

// ===== tb/rcd_core_test.sv
// self-checking bench of the rheostat command decoder
// assumes the host model drives the link and makes the link clock
`timescale 1ns/1ps
module rcd_core_test;
   localparam logic [9:0] TOL_UP = 10'h2a5; // arbitrary
   localparam logic [9:0] TOL_LO = 10'h15a; // arbitrary
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic hw_reset_n = 1'b1;
   logic lclk;
   logic lnk_valid;
   logic lnk_ready;
   logic store_busy;
   logic shutdown;
   logic seen_busy = 1'b0;
   logic [15:0] lnk_word;
   logic [15:0] lnk_rdata;
   logic [9:0] wiper;
   int n_fail = 0;
   int checks_done = 0;
   int ready_in_store = 0;

   always #50 mclk = ~mclk;

   rcd_core #(.STORE_CYCLES(20), .TOL_UPPER(TOL_UP), .TOL_LOWER(TOL_LO)) i_rcd_core (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_hw_reset_n(hw_reset_n), .i_lclk(lclk),
      .i_lnk_valid(lnk_valid), .i_lnk_word(lnk_word), .o_lnk_ready(lnk_ready),
      .o_lnk_rdata(lnk_rdata), .o_wiper(wiper), .o_shutdown(shutdown),
      .o_store_busy(store_busy));

   rcd_host i_rcd_host (.o_lclk(lclk), .o_valid(lnk_valid), .o_word(lnk_word),
      .i_ready(lnk_ready), .i_rdata(lnk_rdata));

   // the link must not take words while the store is programming
   always @(posedge mclk)
   begin
      if (store_busy === 1'b1)
      begin
         seen_busy <= 1'b1;
         if (lnk_ready !== 1'b0)
            ready_in_store <= ready_in_store + 1;
      end
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // answer collected when ready returns is the result of this same word
   task automatic cmd(input logic [15:0] w, input logic [15:0] exp);
      logic [15:0] r;
      bit ok;
      i_rcd_host.send(w, r, ok);
      if (!ok)
      begin
         n_fail++;
         $display("BAD handshake expected ready seen timeout");
         final_report();
      end
      chk("answer", r, exp);
   endtask

   task automatic s_locked();
      chk("wiper", {6'h00, wiper}, 16'h0200);
      cmd(16'h0500, 16'h0500);
      chk("wiper", {6'h00, wiper}, 16'h0200);
      cmd(16'h0c00, 16'h0c00);
      cmd(16'h1800, 16'h0000);
      cmd(16'h2000, 16'h0000);
      cmd(16'h0000, 16'h0000);
   endtask

   task automatic s_unlock();
      cmd(16'h1c03, 16'h1c03);
      cmd(16'h2000, 16'h0003);
      cmd(16'h0500, 16'h0500);
      chk("wiper", {6'h00, wiper}, 16'h0100);
      cmd(16'h0800, 16'h0100);
      cmd(16'h0c00, 16'h0c00);
      chk("busy", {15'h0, seen_busy}, 16'h0001);
      chk("ready", 16'(ready_in_store), 16'h0000);
      cmd(16'h1800, 16'h0001);
      cmd(16'h1401, 16'h0100);
      cmd(16'h2000, 16'h000b);
   endtask

   task automatic s_reset();
      cmd(16'h07ff, 16'h07ff);
      cmd(16'h2401, 16'h2401);
      chk("shutdown", {15'h0, shutdown}, 16'h0001);
      cmd(16'h2400, 16'h2400);
      chk("shutdown", {15'h0, shutdown}, 16'h0000);
      cmd(16'h2401, 16'h2401);
      cmd(16'h1000, 16'h1000);
      chk("wiper", {6'h00, wiper}, 16'h0100);
      chk("shutdown", {15'h0, shutdown}, 16'h0000);
      cmd(16'h07ff, 16'h07ff);
      cmd(16'h2401, 16'h2401);
      @(posedge mclk);
      hw_reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      hw_reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("wiper", {6'h00, wiper}, 16'h0100);
      chk("shutdown", {15'h0, shutdown}, 16'h0000);
      cmd(16'h2000, 16'h0008);
      cmd(16'h0555, 16'h0555);
      chk("wiper", {6'h00, wiper}, 16'h0100);
   endtask

   task automatic s_tol();
      cmd(16'h1439, {6'h00, TOL_UP});
      cmd(16'h143a, {6'h00, TOL_LO});
      cmd(16'h1400, 16'h0000);
      cmd(16'h1402, 16'h0000);
   endtask

   task automatic s_full();
      int i;
      cmd(16'h1c03, 16'h1c03);
      for (i = 2; i <= 50; i++)
      begin
         cmd(16'h0400 | 16'(i), 16'h0400 | 16'(i));
         cmd(16'h0c00, 16'h0c00);
      end
      cmd(16'h1800, 16'h0032);
      cmd(16'h07cc, 16'h07cc);
      cmd(16'h0c00, 16'h0c00);
      cmd(16'h1800, 16'h0032);
      cmd(16'h1432, 16'h0032);
      cmd(16'h1000, 16'h1000);
      chk("wiper", {6'h00, wiper}, 16'h0032);
   endtask

   initial
   begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      s_locked();
      s_unlock();
      s_reset();
      s_tol();
      s_full();
      final_report();
   end
endmodule
